/* design/fadb_channel.sv */
// Channel B control register and activation logic, full address mode.
`timescale 1ns/100ps
// What this block does
// - Channel enabled only while master enable and channel enable both hold one.
// - Non-maskable interrupt clears master enable, suspending the transfer.
// - Suspended transfer resumes when software sets master enable again.
// - Master enable sets only after a read showing zero, then a write.
// - Channel B control clears to zero on reset and in standby.
// - Reserved bit six stores and reads back what software wrote.
// - Step enable zero keeps destination address unchanged.
// - Direction zero steps destination up by one or two per transfer.
// - Direction one steps destination down by one or two per transfer.
// - Block side bit picks destination (0) or source (1) as block area.
// - Normal mode codes 000 and 010 give burst and cycle-steal auto-requests.
// - Normal mode codes 110 and 111 trigger on request falling edge, low level.
// - Block mode codes 000 to 011 select timer channels 0 to 3.
// - Block mode code 110 triggers on request falling edge only.
// - Channels sharing one timer source are serviced in fixed priority order.
// - Full address mode needs both upper pair mode bits set.
// - Lowest pair mode bit picks normal (0) or block (1) mode.
// - Transfer size bit picks byte (0) or word (1).
// - Channel enable clears itself when the transfer count finishes.
module fadb_channel (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic standby,
    input wire fadb_pkg::fadb_bus_s bus,
    output logic [31:0] rdata,
    input wire logic nmi_pin,
    input wire logic ext_req_n_pin,
    input wire logic [fadb_pkg::TMR_N-1:0] timer_irq,
    input wire logic prio_hold,
    input wire logic xfer_ack,
    input wire logic block_end,
    output fadb_pkg::fadb_xfer_s xfer,
    output logic [fadb_pkg::ADDR_W-1:0] dest_addr
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [fadb_pkg::ADDR_W-1:0] dest;
        logic [fadb_pkg::ADDR_W-1:0] dest_start;
        logic [fadb_pkg::CNT_W-1:0] count;
        logic armed_a;
        logic armed_b;
        logic nmi_s1;
        logic nmi_s2;
        logic nmi_prev;
        logic req_s1;
        logic req_s2;
        logic req_prev;
        logic pending;
        logic [31:0] rdata;
    } fadb_state_s;

    fadb_state_s st_ff;
    fadb_state_s nxt_st;

    // Timer sources are the block mode codes with the top activation bit clear.
    function automatic logic is_timer(input logic [2:0] code,
                                      input logic blk);
        is_timer = blk && !code[fadb_pkg::B_ACT_HI];
    endfunction

    logic full_mode;
    logic blk_mode;
    logic enabled;
    logic [2:0] act;
    logic timer_sel;
    logic auto_req;
    logic low_req;
    logic fall_ev;
    logic set_pend;
    logic clr_pend;
    logic dec_ev;
    logic wr_a;
    logic wr_b;
    logic wr_dest;
    logic wr_cnt;
    logic [fadb_pkg::ADDR_W-1:0] step;

    always_comb begin
        full_mode = st_ff.ctrl_a[fadb_pkg::A_MODE2]
            && st_ff.ctrl_a[fadb_pkg::A_MODE1];
        blk_mode = st_ff.ctrl_a[fadb_pkg::A_BLOCK];
        enabled = full_mode && st_ff.ctrl_b[fadb_pkg::B_MASTER]
            && st_ff.ctrl_a[fadb_pkg::A_ENABLE];
        act = st_ff.ctrl_b[fadb_pkg::B_ACT_HI:0];
        timer_sel = is_timer(act, blk_mode);
        auto_req = !blk_mode && (act == fadb_pkg::ACT_BURST
            || act == fadb_pkg::ACT_CYCLE);
        low_req = !blk_mode && act == fadb_pkg::ACT_LOW
            && !st_ff.req_s2;
        fall_ev = act == fadb_pkg::ACT_FALL && st_ff.req_prev
            && !st_ff.req_s2;
        set_pend = enabled && (fall_ev
            || (timer_sel && timer_irq[act[1:0]]));
        clr_pend = blk_mode ? block_end : xfer_ack;
        dec_ev = enabled && (blk_mode ? block_end : xfer_ack);
        wr_a = bus.wr && bus.addr == fadb_pkg::ADDR_CTRL_A;
        wr_b = bus.wr && bus.addr == fadb_pkg::ADDR_CTRL_B;
        wr_dest = bus.wr && bus.addr == fadb_pkg::ADDR_DEST;
        wr_cnt = bus.wr && bus.addr == fadb_pkg::ADDR_COUNT;
        step = st_ff.ctrl_a[fadb_pkg::A_SIZE] ? fadb_pkg::STEP_WORD
            : fadb_pkg::STEP_BYTE;
    end

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.nmi_s1 = nmi_pin;
        nxt_st.nmi_s2 = st_ff.nmi_s1;
        nxt_st.nmi_prev = st_ff.nmi_s2;
        nxt_st.req_s1 = ext_req_n_pin;
        nxt_st.req_s2 = st_ff.req_s1;
        nxt_st.req_prev = st_ff.req_s2;
        nxt_st.rdata = 32'h00000000;
        if (bus.rd) begin
            unique case (bus.addr)
                fadb_pkg::ADDR_CTRL_A: begin
                    nxt_st.rdata[7:0] = st_ff.ctrl_a;
                    if (!st_ff.ctrl_a[fadb_pkg::A_ENABLE]) begin
                        nxt_st.armed_a = 1'b1;
                    end
                end
                fadb_pkg::ADDR_CTRL_B: begin
                    nxt_st.rdata[7:0] = st_ff.ctrl_b;
                    if (!st_ff.ctrl_b[fadb_pkg::B_MASTER]) begin
                        nxt_st.armed_b = 1'b1;
                    end
                end
                fadb_pkg::ADDR_DEST: begin
                    nxt_st.rdata[fadb_pkg::ADDR_W-1:0] = st_ff.dest;
                end
                fadb_pkg::ADDR_COUNT: begin
                    nxt_st.rdata[fadb_pkg::CNT_W-1:0] = st_ff.count;
                end
                default: begin
                    nxt_st.rdata = 32'h00000000;
                end
            endcase
        end
        // The enable bit only rises if the read that armed it saw zero.
        if (wr_a) begin
            nxt_st.ctrl_a = bus.wdata[7:0];
            nxt_st.ctrl_a[fadb_pkg::A_ENABLE] =
                bus.wdata[fadb_pkg::A_ENABLE]
                && (st_ff.armed_a || st_ff.ctrl_a[fadb_pkg::A_ENABLE]);
            nxt_st.armed_a = 1'b0;
        end
        if (wr_b) begin
            nxt_st.ctrl_b = bus.wdata[7:0];
            nxt_st.ctrl_b[fadb_pkg::B_MASTER] =
                bus.wdata[fadb_pkg::B_MASTER]
                && (st_ff.armed_b
                || st_ff.ctrl_b[fadb_pkg::B_MASTER]);
            nxt_st.armed_b = 1'b0;
        end
        if (wr_cnt) begin
            nxt_st.count = bus.wdata[fadb_pkg::CNT_W-1:0];
        end else if (dec_ev) begin
            nxt_st.count = st_ff.count - fadb_pkg::COUNT_ONE;
            if (st_ff.count == fadb_pkg::COUNT_LAST) begin
                nxt_st.ctrl_a[fadb_pkg::A_ENABLE] = 1'b0;
            end
        end
        if (wr_dest) begin
            nxt_st.dest = bus.wdata[fadb_pkg::ADDR_W-1:0];
            nxt_st.dest_start = bus.wdata[fadb_pkg::ADDR_W-1:0];
        end else if (enabled && blk_mode && block_end
                     && !st_ff.ctrl_b[fadb_pkg::B_SIDE]) begin
            nxt_st.dest = st_ff.dest_start;
        end else if (enabled && xfer_ack
                     && st_ff.ctrl_b[fadb_pkg::B_STEP]) begin
            if (st_ff.ctrl_b[fadb_pkg::B_DIR]) begin
                nxt_st.dest = st_ff.dest - step;
            end else begin
                nxt_st.dest = st_ff.dest + step;
            end
        end
        // A request that lands with its own consumption is kept.
        nxt_st.pending = set_pend
            || (st_ff.pending && !(enabled && clr_pend));
        // The interrupt beats a software set in the same cycle.
        if (st_ff.nmi_s2 && !st_ff.nmi_prev) begin
            nxt_st.ctrl_b[fadb_pkg::B_MASTER] = 1'b0;
        end
        if (standby) begin
            nxt_st.ctrl_b = fadb_pkg::CTRL_RESET;
            nxt_st.ctrl_a = fadb_pkg::CTRL_RESET;
            nxt_st.armed_a = 1'b0;
            nxt_st.armed_b = 1'b0;
            nxt_st.pending = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.req_s1 <= 1'b1;
            st_ff.req_s2 <= 1'b1;
            st_ff.req_prev <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    // A shared timer source waits while a higher channel claims it.
    always_comb begin
        xfer.enabled = enabled;
        xfer.req = enabled && (auto_req || low_req || st_ff.pending)
            && !(timer_sel && prio_hold);
        xfer.burst = !blk_mode && act == fadb_pkg::ACT_BURST;
        xfer.word = st_ff.ctrl_a[fadb_pkg::A_SIZE];
        xfer.src_is_block = blk_mode && st_ff.ctrl_b[fadb_pkg::B_SIDE];
        xfer.dest_is_block = blk_mode
            && !st_ff.ctrl_b[fadb_pkg::B_SIDE];
    end
    assign rdata = st_ff.rdata;
    assign dest_addr = st_ff.dest;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_enable;
        xfer.enabled == (st_ff.ctrl_b[7] && st_ff.ctrl_a[7]
            && st_ff.ctrl_a[2] && st_ff.ctrl_a[1]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("Channel enable disagrees with control bits.");

    property p_nmi;
        $rose(st_ff.nmi_s2) && !standby |=> !st_ff.ctrl_b[7];
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("Master enable survived an NMI.");

    property p_arm;
        wr_b && bus.wdata[7] && !st_ff.armed_b && !st_ff.ctrl_b[7]
            |=> !st_ff.ctrl_b[7];
    endproperty
    a_arm: assert property (p_arm)
        else $error("Master enable set without a prior read.");

    property p_standby;
        standby |=> st_ff.ctrl_b == 8'h00;
    endproperty
    a_standby: assert property (p_standby)
        else $error("Standby did not clear channel B control.");

    property p_rsvd;
        wr_b && !standby |=> st_ff.ctrl_b[6] == $past(bus.wdata[6]);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("Reserved bit did not store the written value.");

    property p_hold;
        xfer_ack && !st_ff.ctrl_b[4] && !wr_dest && !block_end
            |=> $stable(dest_addr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Destination moved with stepping disabled.");

    property p_inc;
        enabled && xfer_ack && st_ff.ctrl_b[4] && !st_ff.ctrl_b[5]
            && !wr_dest && !block_end
            |=> dest_addr == $past(st_ff.dest) + $past(step);
    endproperty
    a_inc: assert property (p_inc)
        else $error("Destination did not step up.");

    property p_dec;
        enabled && xfer_ack && st_ff.ctrl_b[4] && st_ff.ctrl_b[5]
            && !wr_dest && !block_end
            |=> dest_addr == $past(st_ff.dest) - $past(step);
    endproperty
    a_dec: assert property (p_dec)
        else $error("Destination did not step down.");

    property p_done;
        dec_ev && !wr_cnt && !wr_a && st_ff.count == 16'h0001
            |=> !st_ff.ctrl_a[7] ##1 !xfer.enabled;
    endproperty
    a_done: assert property (p_done)
        else $error("Channel enable not cleared at end of count.");

    property p_idle;
        !enabled |-> !xfer.req;
    endproperty
    a_idle: assert property (p_idle)
        else $error("Transfer requested while the channel is disabled.");

    property p_disarm;
        wr_b |=> !st_ff.armed_b;
    endproperty
    a_disarm: assert property (p_disarm)
        else $error("A write to channel B control left it armed.");

    property p_keep;
        st_ff.pending && !enabled && !standby |=> st_ff.pending;
    endproperty
    a_keep: assert property (p_keep)
        else $error("Pending request lost during suspension.");

    property p_reload;
        enabled && blk_mode && block_end && !wr_dest
            && !st_ff.ctrl_b[fadb_pkg::B_SIDE]
            |=> dest_addr == $past(st_ff.dest_start);
    endproperty
    a_reload: assert property (p_reload)
        else $error("Destination block area was not restored.");

    property p_sides;
        !(xfer.src_is_block && xfer.dest_is_block);
    endproperty
    a_sides: assert property (p_sides)
        else $error("Source and destination both marked as block area.");

    property p_auto;
        enabled && auto_req |-> xfer.req;
    endproperty
    a_auto: assert property (p_auto)
        else $error("Auto-request code gave no transfer request.");

    property p_low;
        enabled && low_req |-> xfer.req;
    endproperty
    a_low: assert property (p_low)
        else $error("Low request level gave no transfer request.");

    property p_fall;
        enabled && fall_ev && !standby |=> st_ff.pending;
    endproperty
    a_fall: assert property (p_fall)
        else $error("Falling request edge was not latched.");

    property p_timer;
        enabled && timer_sel && timer_irq[act[1:0]] && !standby
            |=> st_ff.pending;
    endproperty
    a_timer: assert property (p_timer)
        else $error("Selected timer pulse was not latched.");

    property p_prio;
        timer_sel && prio_hold |-> !xfer.req;
    endproperty
    a_prio: assert property (p_prio)
        else $error("Request raised while a higher channel owns the timer.");
endmodule // fadb_channel

/* design/fadb_pkg.sv */
// Constants and carrier types for the full address channel B control block.
package fadb_pkg;
    // ==========================================================
    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_DEST = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ==========================================================
    // Channel B control fields
    localparam int B_MASTER = 7;
    localparam int B_RSVD = 6;
    localparam int B_DIR = 5;
    localparam int B_STEP = 4;
    localparam int B_SIDE = 3;
    localparam int B_ACT_HI = 2;
    // ==========================================================
    // Channel A control fields
    localparam int A_ENABLE = 7;
    localparam int A_SIZE = 6;
    localparam int A_MODE2 = 2;
    localparam int A_MODE1 = 1;
    localparam int A_BLOCK = 0;
    // ==========================================================
    // Activation codes
    localparam logic [2:0] ACT_BURST = 3'h0;
    localparam logic [2:0] ACT_CYCLE = 3'h2;
    localparam logic [2:0] ACT_FALL = 3'h6;
    localparam logic [2:0] ACT_LOW = 3'h7;
    // ==========================================================
    // Widths and address steps
    localparam int ADDR_W = 24;
    localparam int CNT_W = 16;
    localparam int TMR_N = 4;
    localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;
    localparam logic [CNT_W-1:0] COUNT_LAST = 16'h0001;
    localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fadb_bus_s;

    typedef struct packed {
        logic req;
        logic burst;
        logic word;
        logic src_is_block;
        logic dest_is_block;
        logic enabled;
    } fadb_xfer_s;
endpackage

/* dv/fadb_far_side.sv */
// Far-side model: external request source and transfer acknowledger.
`timescale 1ns/100ps
module fadb_far_side (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req,
    input wire logic ack_on,
    input wire logic fire,
    input wire logic [3:0] lat,
    output logic ext_req_n_pin,
    output logic xfer_ack
);
    logic [3:0] low_cnt;
    logic [3:0] wait_cnt;
    logic owe;
    // The request line has a pull-up, so it sits high between requests.
    assign ext_req_n_pin = (low_cnt == 4'h0);
    // One acknowledge is owed per ack_on pulse, so the bench knows the step count.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            low_cnt <= 4'h0;
            wait_cnt <= 4'h0;
            owe <= 1'b0;
            xfer_ack <= 1'b0;
        end else begin
            xfer_ack <= 1'b0;
            if (fire) low_cnt <= 4'h6;
            else if (low_cnt != 4'h0) low_cnt <= low_cnt - 4'h1;
            if (ack_on) owe <= 1'b1;
            if (owe && req) begin
                if (wait_cnt == lat) begin
                    xfer_ack <= 1'b1;
                    owe <= 1'b0;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule // fadb_far_side

/* dv/full_address_dma_channel_b_control_test.sv */
// Self-checking testbench for the channel B control block.
`timescale 1ns/100ps
module full_address_dma_channel_b_control_test;
    localparam logic [7:0] CA = fadb_pkg::ADDR_CTRL_A;
    localparam logic [7:0] CB = fadb_pkg::ADDR_CTRL_B;
    localparam logic [7:0] DA = fadb_pkg::ADDR_DEST;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic standby = 1'b0;
    logic nmi_pin = 1'b0;
    logic prio_hold = 1'b0;
    logic block_end = 1'b0;
    logic ack_on = 1'b0;
    logic fire = 1'b0;
    logic [3:0] timer_irq = 4'h0;
    logic [3:0] lat = 4'h0;
    fadb_pkg::fadb_bus_s bus = '0;
    fadb_pkg::fadb_xfer_s xfer;
    logic [31:0] rdata;
    logic [31:0] tmp;
    logic [fadb_pkg::ADDR_W-1:0] dest_addr;
    logic ext_req_n_pin;
    logic xfer_ack;
    int num_errors = 0;
    int total_checks = 0;
    logic [7:0] ta [7] = '{8'h86, 8'h86, 8'h86, 8'hc6, 8'h86, 8'hc6, 8'h86};
    logic [7:0] tb [7] = '{8'h80, 8'ha0, 8'h90, 8'h90, 8'hb0, 8'hb0, 8'hd0};
    logic [23:0] td [7] = '{24'h0, 24'h0, 24'h1, 24'h2, 24'hffffff,
        24'hfffffe, 24'h1};
    always #5 core_clk = ~core_clk;
    fadb_channel fadb_channel_i (.core_clk(core_clk), .rst(rst),
        .standby(standby), .bus(bus), .rdata(rdata), .nmi_pin(nmi_pin),
        .ext_req_n_pin(ext_req_n_pin), .timer_irq(timer_irq),
        .prio_hold(prio_hold), .xfer_ack(xfer_ack), .block_end(block_end),
        .xfer(xfer), .dest_addr(dest_addr));
    fadb_far_side fadb_far_side_i (.core_clk(core_clk), .rst(rst),
        .req(xfer.req), .ack_on(ack_on), .fire(fire), .lat(lat),
        .ext_req_n_pin(ext_req_n_pin), .xfer_ack(xfer_ack));
    // ==========================================================
    // Bus and check helpers
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [7:0] a,
        input logic [31:0] e);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask
    // Enable bits only stick after a read that saw them clear.
    task automatic arm(input logic [7:0] a, input logic [7:0] v);
        wr(a, 32'h0);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        wr(a, {24'h0, v});
    endtask
    task automatic setup(input logic [7:0] a, b);
        wr(fadb_pkg::ADDR_COUNT, 32'h10);
        arm(CA, a);
        arm(CB, b);
        cyc(1);
    endtask
    task automatic pulse(input logic [3:0] t, input logic be, f, sb);
        @(posedge core_clk);
        timer_irq <= t;
        block_end <= be;
        fire <= f;
        standby <= sb;
        @(posedge core_clk);
        timer_irq <= 4'h0;
        block_end <= 1'b0;
        fire <= 1'b0;
        standby <= 1'b0;
        #1;
    endtask
    task automatic ack1;
        int i;
        @(posedge core_clk);
        ack_on <= 1'b1;
        @(posedge core_clk);
        ack_on <= 1'b0;
        i = 0;
        while (xfer_ack !== 1'b1 && i < 40) begin
            cyc(1);
            i++;
        end
        chk("ack", 32'h1, {31'h0, xfer_ack});
        cyc(1);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs;
        rdchk("ctrl_a reset", CA, 32'h0);
        rdchk("ctrl_b reset", CB, 32'h0);
        rdchk("unmapped", 8'h20, 32'h0);
        wr(CB, 32'h40);
        wr(CB, 32'hc0);
        rdchk("unarmed set", CB, 32'h40);
        wr(CB, 32'hc0);
        rdchk("armed set", CB, 32'hc0);
        pulse(4'h0, 1'b0, 1'b0, 1'b1);
        rdchk("ctrl_b standby", CB, 32'h0);
    endtask
    task automatic t_step;
        for (int i = 0; i < 7; i++) begin
            wr(DA, 32'h100);
            setup(ta[i], tb[i]);
            chk("word", {31'h0, ta[i][6]}, {31'h0, xfer.word});
            ack1;
            chk("dest", {8'h0, 24'h100 + td[i]}, {8'h0, dest_addr});
        end
    endtask
    task automatic t_nmi;
        lat <= 4'h3;
        wr(DA, 32'h200);
        setup(8'h86, 8'h90);
        @(posedge core_clk);
        nmi_pin <= 1'b1;
        cyc(3);
        @(posedge core_clk);
        nmi_pin <= 1'b0;
        cyc(6);
        chk("enabled nmi", 32'h0, {31'h0, xfer.enabled});
        rdchk("ctrl_b nmi", CB, 32'h10);
        wr(CB, 32'h90);
        cyc(1);
        chk("enabled again", 32'h1, {31'h0, xfer.enabled});
        ack1;
        chk("dest resume", 32'h201, {8'h0, dest_addr});
    endtask
    task automatic t_auto;
        setup(8'h86, 8'h80);
        chk("burst req", 32'h3, {30'h0, xfer.req, xfer.burst});
        setup(8'h86, 8'h82);
        chk("steal req", 32'h2, {30'h0, xfer.req, xfer.burst});
    endtask
    task automatic t_pin;
        setup(8'h86, 8'h86);
        chk("edge idle", 32'h0, {31'h0, xfer.req});
        pulse(4'h0, 1'b0, 1'b1, 1'b0);
        cyc(10);
        chk("edge pending", 32'h1, {31'h0, xfer.req});
        ack1;
        chk("edge done", 32'h0, {31'h0, xfer.req});
        setup(8'h86, 8'h87);
        pulse(4'h0, 1'b0, 1'b1, 1'b0);
        cyc(4);
        chk("level low", 32'h1, {31'h0, xfer.req});
        cyc(8);
        chk("level high", 32'h0, {31'h0, xfer.req});
    endtask
    task automatic t_block;
        for (int k = 0; k < 4; k++) begin
            setup(8'h87, 8'h80 | 8'(k[0] << 3) | 8'(k));
            pulse(4'h1 << ((k + 1) % 4), 1'b0, 1'b0, 1'b0);
            chk("other timer", 32'h0, {31'h0, xfer.req});
            pulse(4'h1 << k, 1'b0, 1'b0, 1'b0);
            chk("timer req", 32'h1, {31'h0, xfer.req});
            chk("sides", {30'h0, k[0], ~k[0]},
                {30'h0, xfer.src_is_block, xfer.dest_is_block});
            @(posedge core_clk);
            prio_hold <= 1'b1;
            #1 chk("prio hold", 32'h0, {31'h0, xfer.req});
            @(posedge core_clk);
            prio_hold <= 1'b0;
            #1 chk("prio release", 32'h1, {31'h0, xfer.req});
            pulse(4'h0, 1'b1, 1'b0, 1'b0);
            chk("block done", 32'h0, {31'h0, xfer.req});
        end
        setup(8'h87, 8'h86);
        pulse(4'h0, 1'b0, 1'b1, 1'b0);
        cyc(10);
        chk("block edge", 32'h1, {31'h0, xfer.req});
    endtask
    task automatic t_count;
        lat <= 4'h5;
        setup(8'h86, 8'h80);
        wr(fadb_pkg::ADDR_COUNT, 32'h1);
        ack1;
        rdchk("ctrl_a end", CA, 32'h06);
        chk("enabled end", 32'h0, {31'h0, xfer.enabled});
    endtask
    // ==========================================================
    // Run control
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_regs;
        t_step;
        t_nmi;
        t_auto;
        t_pin;
        t_block;
        t_count;
        conclude;
    end
    // The whole run needs under a thousand cycles; ten thousand means a hang.
    initial begin
        #100us;
        num_errors++;
        conclude;
    end
endmodule // full_address_dma_channel_b_control_test
